// ===== rtl/rstic_top.sv
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module rstic_top
    import rstic_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // pins and analog detector
    input wire logic i_reset_pin_n,
    output logic o_reset_pin_o,
    output logic o_reset_pin_oe,
    input wire logic i_low_supply,
    input wire logic i_ext_line_n,
    input wire logic i_shared_port_pin,
    input wire logic [7:0] i_keypad_pins,
    // timer block, same clock
    input wire logic i_timer_overflow_flag,
    input wire logic i_timer_request_mask,
    // cpu core
    input wire logic i_boundary,
    input wire logic i_swi_fetch,
    input wire logic i_swi_instr,
    input wire logic i_rti,
    input wire logic i_rti_ibit,
    input wire logic i_ccr_write,
    input wire logic i_ccr_ibit,
    output logic o_cpu_reset,
    output logic o_ibit,
    output logic o_irq_pending,
    output rstic_cpu_req_t o_req,
    output logic o_slow_clock_select
);
    logic [11:0] pins_s;
    logic pin_n_s, low_s, ext_s, pd6_s;
    logic [7:0] kp_s;
    rstic_state_t st_q, st_d;
    logic [11:0] cnt_q, cnt_d;
    logic rst_q, rst_d, dev_rst;
    rstic_misc_t misc_q, misc_d, misc_rst;
    logic [7:0] kp_en_q, kp_en_d;
    logic [9:0] prev_q, prev_d;
    logic ext_lat_q, ext_lat_d, sec_lat_q, sec_lat_d, kp_lat_q, kp_lat_d;
    logic ibit_q, ibit_d;
    logic [3:0] snap_q, snap_d, hw_pend, sel_pend;
    rstic_cpu_req_t req_q, req_d;
    logic pend_q, pend_d;
    logic rdy_q, rdy_d;
    logic [31:0] rdata_q, rdata_d;
    logic wr_en, hit_kp, hit_misc, hit_stat;
    logic ext_fall, sec_fall;
    logic [7:0] kp_fall;

    // every pin crosses two flops before use; pins idle high, supply idle ok
    rstic_sync #(.W(12), .RST_VAL(12'hbff)) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_d({i_reset_pin_n, i_low_supply, i_ext_line_n, i_shared_port_pin, i_keypad_pins}),
        .o_q(pins_s)
    );
    assign pin_n_s = pins_s[11];
    assign low_s = pins_s[10];
    assign ext_s = pins_s[9];
    assign pd6_s = pins_s[8];
    assign kp_s = pins_s[7:0];

    // reset sequencer; counter only restarts on power-up
    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        case (st_q)
            ST_POR_HOLD:
            begin
                cnt_d = cnt_q + 12'h001;
                if (cnt_q == POWER_UP_HOLD_CYCLES - 12'h001)
                begin
                    st_d = ST_PIN_WAIT;
                end
            end
            ST_PIN_WAIT:
            begin
                if (pin_n_s)
                begin
                    st_d = ST_RUN;
                end
            end
            ST_RUN: st_d = ST_RUN;
            default: st_d = ST_POR_HOLD;
        endcase
        // pin and enabled low supply both hold the core in reset
        rst_d = (st_q != ST_RUN) || !pin_n_s
            || (misc_q.low_supply_reset_enable && low_s);
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            st_q <= ST_POR_HOLD;
            cnt_q <= 12'h000;
            rst_q <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            rst_q <= rst_d;
        end
    end

    // pin pulled low internally for the whole hold period
    assign o_reset_pin_o = 1'b0;
    assign o_reset_pin_oe = (st_q == ST_POR_HOLD);
    assign o_cpu_reset = rst_q;
    // any reset returns the registers but only power-up clears the low-supply enable; low-supply reset lasts while supply is low
    assign dev_rst = i_sys_rst || rst_q;

    // apb decode; one wait state so read data comes from a flop
    assign hit_kp = (i_paddr[7:2] == KEYPAD_ENABLE_IDX) && (i_paddr[1:0] == 2'b00);
    assign hit_misc = (i_paddr[7:2] == MISC_CONTROL_IDX) && (i_paddr[1:0] == 2'b00);
    assign hit_stat = (i_paddr[7:2] == STATUS_IDX) && (i_paddr[1:0] == 2'b00);
    assign wr_en = i_psel && i_penable && rdy_q && i_pwrite;

    // edge detectors on synchronised pins
    assign ext_fall = prev_q[9] && !ext_s;
    assign sec_fall = prev_q[8] && !pd6_s;
    assign kp_fall = prev_q[7:0] & ~kp_s;

    // control registers and source latches
    always_comb
    begin
        misc_d = misc_q;
        kp_en_d = kp_en_q;
        // power-up clears the low-supply enable, its own reset must not
        misc_rst = rstic_misc_t'(MISC_CONTROL_RESET);
        misc_rst.low_supply_reset_enable = misc_q.low_supply_reset_enable && !i_sys_rst;
        if (wr_en && hit_misc)
        begin
            misc_d = rstic_misc_t'(i_pwdata[7:0]);
        end
        if (wr_en && hit_kp)
        begin
            kp_en_d = i_pwdata[7:0];
        end
        // clear bits are write-only strobes and never stored
        misc_d.keypad_latch_clear = 1'b0;
        misc_d.second_line_latch_clear = 1'b0;
        prev_d = {ext_s, pd6_s, kp_s};
        ext_lat_d = ext_lat_q;
        if (req_q.take && req_q.vector == VEC_EXT)
        begin
            ext_lat_d = 1'b0;
        end
        if (misc_q.ext_line_enable && misc_q.ext_line_edge_sel && ext_fall)
        begin
            ext_lat_d = 1'b1;
        end
        sec_lat_d = sec_lat_q;
        if (wr_en && hit_misc && i_pwdata[1])
        begin
            sec_lat_d = 1'b0;
        end
        if (misc_q.second_line_enable && sec_fall)
        begin
            sec_lat_d = 1'b1;
        end
        kp_lat_d = kp_lat_q;
        if (wr_en && hit_misc && i_pwdata[6])
        begin
            kp_lat_d = 1'b0;
        end
        if (misc_q.keypad_master_enable && |(kp_fall & kp_en_q))
        begin
            kp_lat_d = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (dev_rst)
        begin
            misc_q <= misc_rst;
            kp_en_q <= KEYPAD_ENABLE_RESET;
            prev_q <= 10'h3ff;
            ext_lat_q <= 1'b0;
            sec_lat_q <= 1'b0;
            kp_lat_q <= 1'b0;
        end
        else
        begin
            misc_q <= misc_d;
            kp_en_q <= kp_en_d;
            prev_q <= prev_d;
            ext_lat_q <= ext_lat_d;
            sec_lat_q <= sec_lat_d;
            kp_lat_q <= kp_lat_d;
        end
    end

    // level mode re-requests while the wired line stays low
    always_comb
    begin
        hw_pend = 4'h0;
        hw_pend[PEND_EXT] = misc_q.ext_line_enable
            && (misc_q.ext_line_edge_sel ? ext_lat_q : !ext_s);
        hw_pend[PEND_SECOND] = misc_q.second_line_enable && sec_lat_q;
        hw_pend[PEND_TIMER] = i_timer_overflow_flag && !i_timer_request_mask;
        hw_pend[PEND_KEYPAD] = misc_q.keypad_master_enable && kp_lat_q;
    end

    // arbitration, evaluated only at instruction boundaries
    always_comb
    begin
        req_d = req_q;
        req_d.take = 1'b0;
        req_d.software_trap_instr = 1'b0;
        snap_d = snap_q;
        ibit_d = ibit_q;
        sel_pend = 4'h0;
        if (i_swi_fetch)
        begin
            snap_d = hw_pend;
        end
        if (i_ccr_write)
        begin
            ibit_d = i_ccr_ibit;
        end
        if (i_rti)
        begin
            ibit_d = i_rti_ibit;
        end
        if (i_boundary)
        begin
            // trap runs after requests pending at its fetch only
            sel_pend = i_swi_instr ? (hw_pend & snap_q) : hw_pend;
            if (!ibit_q && |sel_pend)
            begin
                req_d.take = 1'b1;
                ibit_d = 1'b1;
                if (sel_pend[PEND_EXT])
                begin
                    req_d.vector = VEC_EXT;
                end
                else if (sel_pend[PEND_SECOND])
                begin
                    req_d.vector = VEC_SECOND;
                end
                else if (sel_pend[PEND_TIMER])
                begin
                    req_d.vector = VEC_TIMER;
                end
                else
                begin
                    req_d.vector = VEC_KEYPAD;
                end
            end
            else if (i_swi_instr)
            begin
                req_d.take = 1'b1;
                req_d.software_trap_instr = 1'b1;
                req_d.vector = VEC_SWI;
                ibit_d = 1'b1;
            end
        end
        pend_d = !ibit_q && |hw_pend;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (dev_rst)
        begin
            req_q <= '{take: 1'b0, software_trap_instr: 1'b0, vector: VEC_RESET};
            ibit_q <= 1'b1;
            snap_q <= 4'h0;
            pend_q <= 1'b0;
        end
        else
        begin
            req_q <= req_d;
            ibit_q <= ibit_d;
            snap_q <= snap_d;
            pend_q <= pend_d;
        end
    end

    // clear strobes read as zero; unmapped addresses flag an error
    always_comb
    begin
        rdy_d = i_psel && i_penable && !rdy_q;
        rdata_d = 32'h0000_0000;
        if (hit_misc)
        begin
            rdata_d[7:0] = misc_q;
        end
        else if (hit_kp)
        begin
            rdata_d[7:0] = kp_en_q;
        end
        else if (hit_stat)
        begin
            rdata_d[STAT_EXT] = ext_lat_q;
            rdata_d[STAT_SECOND] = sec_lat_q;
            rdata_d[STAT_KEYPAD] = kp_lat_q;
            rdata_d[STAT_IBIT] = ibit_q;
            rdata_d[STAT_RESET] = rst_q;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            rdy_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            rdy_q <= rdy_d;
            rdata_q <= rdata_d;
        end
    end

    assign o_pready = rdy_q;
    assign o_prdata = rdata_q;
    assign o_pslverr = rdy_q && !(hit_kp || hit_misc || hit_stat);
    assign o_ibit = ibit_q;
    assign o_irq_pending = pend_q;
    assign o_req = req_q;
    assign o_slow_clock_select = misc_q.slow_clock_select;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);

    a_por_pin_drive: assert property (st_q == ST_POR_HOLD |-> o_reset_pin_oe && o_cpu_reset)
        else $error("reset pin not driven during power-up hold");
    a_reset_vector: assert property (o_cpu_reset |=> o_req.vector == VEC_RESET && ibit_q)
        else $error("reset does not present reset vector with mask set");
    a_pin_wait: assert property (st_q == ST_PIN_WAIT && !pin_n_s |=> o_cpu_reset)
        else $error("reset released while pin still low");
    a_low_supply: assert property (misc_q.low_supply_reset_enable && low_s |=> o_cpu_reset)
        else $error("enabled low supply did not reset");
    a_mask_blocks: assert property (ibit_q && !i_swi_instr |=> !o_req.take)
        else $error("maskable request taken with mask set");
    a_take_masks: assert property (o_req.take |-> ibit_q && $past(i_boundary))
        else $error("take without boundary or mask set");
    a_rti_restore: assert property (i_rti && !i_boundary && !o_cpu_reset && !rst_d
        |=> ibit_q == $past(i_rti_ibit))
        else $error("return did not restore mask");
    a_swi_masked: assert property (i_boundary && i_swi_instr && ibit_q && !o_cpu_reset && !rst_d
        |=> o_req.take && o_req.software_trap_instr && o_req.vector == VEC_SWI)
        else $error("trap not taken under mask");
    a_second_clear: assert property (wr_en && hit_misc && i_pwdata[1] && !sec_fall && !rst_d
        |=> !sec_lat_q)
        else $error("second line latch not cleared");

    c_ext_taken: cover property (o_req.take && o_req.vector == VEC_EXT);
    c_swi_taken: cover property (o_req.take && o_req.software_trap_instr);
    c_keypad_taken: cover property (o_req.take && o_req.vector == VEC_KEYPAD);
    c_pin_wait: cover property (st_q == ST_PIN_WAIT ##1 st_q == ST_PIN_WAIT);
endmodule
`default_nettype wire

// ===== rtl/rstic_pkg.sv
package rstic_pkg;

    // oscillator settle time, already in bus clock cycles (plain default)
    localparam logic [11:0] POWER_UP_HOLD_CYCLES = 12'hfe0;

    // two-byte vector addresses, in address order; the hardware ones highest priority first
    localparam logic [15:0] VEC_RESET = 16'h1ffe;
    localparam logic [15:0] VEC_SWI = 16'h1ffc;
    localparam logic [15:0] VEC_EXT = 16'h1ffa;
    localparam logic [15:0] VEC_SECOND = 16'h1ff8;
    localparam logic [15:0] VEC_TIMER = 16'h1ff6;
    localparam logic [15:0] VEC_KEYPAD = 16'h1ff4;

    // register indices; byte address is four times the index
    localparam logic [5:0] KEYPAD_ENABLE_IDX = 6'h0b;
    localparam logic [5:0] MISC_CONTROL_IDX = 6'h0c;
    localparam logic [5:0] STATUS_IDX = 6'h10;

    localparam logic [7:0] MISC_CONTROL_RESET = 8'h10;
    localparam logic [7:0] KEYPAD_ENABLE_RESET = 8'h00;

    // hardware pending vector bit positions
    localparam int PEND_EXT = 3;
    localparam int PEND_SECOND = 2;
    localparam int PEND_TIMER = 1;
    localparam int PEND_KEYPAD = 0;

    // status register bit positions
    localparam int STAT_EXT = 0;
    localparam int STAT_SECOND = 1;
    localparam int STAT_KEYPAD = 2;
    localparam int STAT_IBIT = 3;
    localparam int STAT_RESET = 4;

    // misc_control layout, bit 7 first
    typedef struct packed {
        logic keypad_master_enable;
        logic keypad_latch_clear;
        logic ext_line_edge_sel;
        logic ext_line_enable;
        logic low_supply_reset_enable;
        logic slow_clock_select;
        logic second_line_latch_clear;
        logic second_line_enable;
    } rstic_misc_t;

    // request handed to the cpu core
    typedef struct packed {
        logic take;
        logic software_trap_instr;
        logic [15:0] vector;
    } rstic_cpu_req_t;

    typedef enum logic [1:0] {
        ST_POR_HOLD = 2'b00,
        ST_PIN_WAIT = 2'b01,
        ST_RUN = 2'b10
    } rstic_state_t;

endpackage

// ===== rtl/rstic_sync.sv
`timescale 1ns/1ps
`default_nettype none
module rstic_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    // two flops; the first is read only by the second
    always_comb
    begin
        meta_d = i_d;
        sync_d = meta_q;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign o_q = sync_q;
endmodule
`default_nettype wire

// ===== tb/rstic_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module rstic_cpu_model
    import rstic_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_ibit,
    input wire logic i_take,
    output logic o_boundary,
    output logic o_swi_fetch,
    output logic o_swi_instr,
    output logic o_rti,
    output logic o_rti_ibit,
    output logic o_ccr_write,
    output logic o_ccr_ibit
);
    logic mask_seen;
    logic stacked;

    // idle core; mask assumed set as after reset
    initial
    begin
        {o_boundary, o_swi_fetch, o_swi_instr, o_rti} = '0;
        {o_rti_ibit, o_ccr_write, o_ccr_ibit} = '0;
        mask_seen = 1'b1;
        stacked = 1'b1;
    end

    // stack only the mask seen at a boundary that was really taken
    always @(posedge i_ref_clk)
    begin
        if (o_boundary)
            mask_seen <= i_ibit;
        if (i_take)
            stacked <= mask_seen;
    end

    // instruction completes; a trap is flagged with it
    task automatic finish(input logic software_trap_instr);
        @(posedge i_ref_clk);
        o_boundary <= 1'b1;
        o_swi_instr <= software_trap_instr;
        @(posedge i_ref_clk);
        o_boundary <= 1'b0;
        o_swi_instr <= 1'b0;
    endtask

    task automatic fetch_trap();
        @(posedge i_ref_clk);
        o_swi_fetch <= 1'b1;
        @(posedge i_ref_clk);
        o_swi_fetch <= 1'b0;
    endtask

    task automatic ret();
        @(posedge i_ref_clk);
        o_rti <= 1'b1;
        o_rti_ibit <= stacked;
        @(posedge i_ref_clk);
        o_rti <= 1'b0;
    endtask

    task automatic set_mask(input logic v);
        @(posedge i_ref_clk);
        o_ccr_write <= 1'b1;
        o_ccr_ibit <= v;
        @(posedge i_ref_clk);
        o_ccr_write <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== tb/reset_and_interrupt_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module reset_and_interrupt_control_tb
    import rstic_pkg::*;
();
    localparam logic [7:0] A_MISC = {MISC_CONTROL_IDX, 2'b00};
    localparam logic [7:0] A_KEYS = {KEYPAD_ENABLE_IDX, 2'b00};
    localparam logic [7:0] A_STAT = {STATUS_IDX, 2'b00};
    logic clk, rst, psel, penable, pwrite, pin_ext, low_sup, ext_n, port_pin, tflag, tmask;
    logic [7:0] paddr, keys;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, pin_o, pin_oe, cpu_rst, ibit, irq_pend, slow, pin_n;
    logic bnd, sfetch, sinstr, return_from_trap_instr, rti_ibit, ccrw, ccr_ibit;
    rstic_cpu_req_t req;
    int n_errors, n_tests;

    // pulled-up reset pin, the device only sinks it
    assign pin_n = pin_ext & ~(pin_oe & ~pin_o);

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    rstic_top u_rstic_top (.i_ref_clk(clk), .i_sys_rst(rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_reset_pin_n(pin_n), .o_reset_pin_o(pin_o), .o_reset_pin_oe(pin_oe),
        .i_low_supply(low_sup), .i_ext_line_n(ext_n), .i_shared_port_pin(port_pin),
        .i_keypad_pins(keys), .i_timer_overflow_flag(tflag),
        .i_timer_request_mask(tmask), .i_boundary(bnd), .i_swi_fetch(sfetch),
        .i_swi_instr(sinstr), .i_rti(return_from_trap_instr), .i_rti_ibit(rti_ibit), .i_ccr_write(ccrw),
        .i_ccr_ibit(ccr_ibit), .o_cpu_reset(cpu_rst), .o_ibit(ibit),
        .o_irq_pending(irq_pend), .o_req(req), .o_slow_clock_select(slow));

    rstic_cpu_model u_rstic_cpu_model (.i_ref_clk(clk), .i_ibit(ibit),
        .i_take(req.take), .o_boundary(bnd), .o_swi_fetch(sfetch),
        .o_swi_instr(sinstr), .o_rti(return_from_trap_instr), .o_rti_ibit(rti_ibit),
        .o_ccr_write(ccrw), .o_ccr_ibit(ccr_ibit));

    task automatic final_report();
        $display("tests %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one apb transfer; the request stands until pready is sampled
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
        begin
            n_errors++;
            final_report();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, {24'h000000, d}, rd, err);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h00000000, rd, err);
        check("prdata", rd, exp);
        check("pslverr", err, eerr);
    endtask

    // one instruction boundary and whatever request it yields
    task automatic serve(input logic software_trap_instr, input logic et, input logic [15:0] ev);
        rstic_cpu_req_t got;
        got = '0;
        u_rstic_cpu_model.finish(software_trap_instr);
        repeat (4)
        begin
            @(negedge clk);
            if (req.take === 1'b1)
                got = req;
        end
        @(posedge clk);
        check("take", got.take, et);
        if (et)
        begin
            check("vector", got.vector, ev);
            check("swi", got.software_trap_instr, ev == VEC_SWI);
            check("ibit", ibit, 1'b1);
        end
    endtask

    task automatic wait_rst(input logic lvl, input int lim);
        int n;
        n = 0;
        while (cpu_rst !== lvl && n < lim)
        begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        check("cpu_reset", cpu_rst, lvl);
        if (cpu_rst !== lvl)
            final_report();
    endtask

    task automatic pulse_ext();
        ext_n <= 1'b0;
        cyc(2);
        ext_n <= 1'b1;
        cyc(6);
    endtask

    task automatic t_power_up();
        int n;
        n = 0;
        check("cpu_reset", cpu_rst, 1'b1);
        check("pin_oe", pin_oe, 1'b1);
        check("ibit", ibit, 1'b1);
        check("vector", req.vector, VEC_RESET);
        rst <= 1'b0;
        while (pin_oe === 1'b1 && n < 5000)
        begin
            @(negedge clk);
            n++;
        end
        check("hold", n >= POWER_UP_HOLD_CYCLES && n <= POWER_UP_HOLD_CYCLES + 4, 1'b1);
        cyc(20);
        check("cpu_reset", cpu_rst, 1'b1);
        pin_ext <= 1'b1;
        wait_rst(1'b0, 20);
        rdc(A_MISC, {24'h000000, MISC_CONTROL_RESET}, 1'b0);
        rdc(A_KEYS, 32'h00000000, 1'b0);
        rdc(8'h34, 32'h00000000, 1'b1);
        rdc(A_MISC + 8'h01, 32'h00000000, 1'b1);
        wr(A_MISC, 8'hff);
        rdc(A_MISC, 32'h000000bd, 1'b0);
        check("slow", slow, 1'b1);
        wr(A_MISC, 8'h30);
        $display("power-up and register test done");
    endtask

    task automatic t_ext_line();
        u_rstic_cpu_model.set_mask(1'b0);
        pulse_ext();
        check("irq_pending", irq_pend, 1'b1);
        serve(1'b0, 1'b1, VEC_EXT);
        cyc(21);
        pulse_ext();
        serve(1'b0, 1'b0, VEC_EXT);
        u_rstic_cpu_model.ret();
        serve(1'b0, 1'b1, VEC_EXT);
        u_rstic_cpu_model.ret();
        serve(1'b0, 1'b0, VEC_EXT);
        wr(A_MISC, 8'h00);
        ext_n <= 1'b0;
        cyc(6);
        serve(1'b0, 1'b0, VEC_EXT);
        wr(A_MISC, 8'h10);
        serve(1'b0, 1'b1, VEC_EXT);
        u_rstic_cpu_model.ret();
        serve(1'b0, 1'b1, VEC_EXT);
        ext_n <= 1'b1;
        cyc(6);
        u_rstic_cpu_model.ret();
        serve(1'b0, 1'b0, VEC_EXT);
        $display("external line test done");
    endtask

    task automatic t_priority();
        wr(A_KEYS, 8'h01);
        wr(A_MISC, 8'h81);
        u_rstic_cpu_model.set_mask(1'b1);
        tflag <= 1'b1;
        tmask <= 1'b0;
        port_pin <= 1'b0;
        keys <= 8'hfe;
        cyc(6);
        check("irq_pending", irq_pend, 1'b0);
        rdc(A_STAT, 32'h0000000e, 1'b0);
        serve(1'b0, 1'b0, VEC_SECOND);
        u_rstic_cpu_model.set_mask(1'b0);
        serve(1'b0, 1'b1, VEC_SECOND);
        wr(A_MISC, 8'h83);
        u_rstic_cpu_model.ret();
        serve(1'b0, 1'b1, VEC_TIMER);
        tmask <= 1'b1;
        u_rstic_cpu_model.ret();
        serve(1'b0, 1'b1, VEC_KEYPAD);
        wr(A_MISC, 8'hc1);
        u_rstic_cpu_model.ret();
        serve(1'b0, 1'b0, VEC_KEYPAD);
        port_pin <= 1'b1;
        keys <= 8'hff;
        $display("priority test done");
    endtask

    task automatic t_trap();
        u_rstic_cpu_model.set_mask(1'b1);
        u_rstic_cpu_model.fetch_trap();
        serve(1'b1, 1'b1, VEC_SWI);
        wr(A_MISC, 8'h10);
        ext_n <= 1'b0;
        u_rstic_cpu_model.set_mask(1'b0);
        cyc(6);
        u_rstic_cpu_model.fetch_trap();
        serve(1'b1, 1'b1, VEC_EXT);
        serve(1'b1, 1'b1, VEC_SWI);
        ext_n <= 1'b1;
        cyc(4);
        // request raised after the fetch must follow the trap
        u_rstic_cpu_model.set_mask(1'b0);
        u_rstic_cpu_model.fetch_trap();
        ext_n <= 1'b0;
        cyc(6);
        serve(1'b1, 1'b1, VEC_SWI);
        ext_n <= 1'b1;
        $display("trap test done");
    endtask

    task automatic t_resets();
        low_sup <= 1'b1;
        cyc(8);
        check("cpu_reset", cpu_rst, 1'b0);
        wr(A_MISC, 8'h18);
        wait_rst(1'b1, 10);
        cyc(8);
        check("cpu_reset", cpu_rst, 1'b1);
        low_sup <= 1'b0;
        wait_rst(1'b0, 5000);
        check("vector", req.vector, VEC_RESET);
        check("ibit", ibit, 1'b1);
        rdc(A_MISC, 32'h00000018, 1'b0);
        pin_ext <= 1'b0;
        cyc(2);
        pin_ext <= 1'b1;
        wait_rst(1'b1, 10);
        wait_rst(1'b0, 5000);
        $display("reset sources test done");
    endtask

    // pin held low through reset so the hold ends with the pin still low
    initial
    begin
        n_errors = 0;
        n_tests = 0;
        {rst, pin_ext, ext_n, port_pin, tmask} = 5'b10111;
        {psel, penable, pwrite, low_sup, tflag} = '0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        keys = 8'hff;
        cyc(16);
        t_power_up();
        t_ext_line();
        t_priority();
        t_trap();
        t_resets();
        final_report();
    end
endmodule
`default_nettype wire
